// ---- common/irq_mask_pkg.sv ----
// Purpose: Constants for the clock-chip interrupt mask bank
// Assumes: AXI4-Lite register access, 32-bit data, 8-bit registers in the low lane
// Notes: Register indices are word indices; byte address is four times the index
package irq_mask_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned NUM_ROWS = 6;

  // ==========================================================================
  // Register indices (byte address = index * 4)
  localparam logic [9:0] IDX_SYSTEM_CLOCK_LOOP_WDOG_NVM = 10'h10A;
  localparam logic [9:0] IDX_REF_AB = 10'h10B;
  localparam logic [9:0] IDX_REF_CD = 10'h10C;
  localparam logic [9:0] IDX_LOOP0_LOCK = 10'h10D;
  localparam logic [9:0] IDX_LOOP0_MODE = 10'h10E;
  localparam logic [9:0] IDX_ANALOG_LOOP0 = 10'h10F;
  localparam logic [9:0] IDX_RECORD_SUMMARY = 10'h113;
  localparam logic [9:0] IDX_FIRST_ROW = IDX_SYSTEM_CLOCK_LOOP_WDOG_NVM;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] MASK_RESET = 8'h00;

  // ==========================================================================
  // Field positions, system clock loop / watchdog / nonvolatile memory row
  localparam int unsigned B_NVM_DONE = 0;
  localparam int unsigned B_NVM_FAULT = 1;
  localparam int unsigned B_WDOG_EXPIRED = 3;
  localparam int unsigned B_SYSTEM_CLOCK_LOOP_LOCKED = 4;
  localparam int unsigned B_SYSTEM_CLOCK_LOOP_STABLE = 5;
  localparam int unsigned B_SYSTEM_CLOCK_LOOP_UNLOCKED = 6;

  // Reference rows: low group for inputs A/C, high group for inputs B/D
  localparam int unsigned B_REF_FAULT = 0;
  localparam int unsigned B_REF_FAULT_CLEARED = 1;
  localparam int unsigned B_REF_VALIDATED = 2;
  localparam int unsigned REF_HIGH_GROUP = 4;

  // Digital loop 0 lock row
  localparam int unsigned B_PHASE_LOCKED = 0;
  localparam int unsigned B_PHASE_UNLOCKED = 1;
  localparam int unsigned B_FREQ_LOCKED = 2;
  localparam int unsigned B_FREQ_UNLOCKED = 3;
  localparam int unsigned B_SLEW_LIMITED = 4;
  localparam int unsigned B_SLEW_UNLIMITED = 5;
  localparam int unsigned B_FREQ_CLAMPED = 6;
  localparam int unsigned B_FREQ_UNCLAMPED = 7;

  // Digital loop 0 mode row
  localparam int unsigned B_ACTIVATED_A = 0;
  localparam int unsigned B_HISTORY_UPDATED = 4;
  localparam int unsigned B_HOLDOVER = 5;
  localparam int unsigned B_FREE_RUN = 6;
  localparam int unsigned B_SWITCHING = 7;

  // Analog loop 0 row
  localparam int unsigned B_CAL_STARTED = 0;
  localparam int unsigned B_CAL_DONE = 1;
  localparam int unsigned B_ALOOP_LOCKED = 2;
  localparam int unsigned B_ALOOP_UNLOCKED = 3;
  localparam int unsigned B_DIST_SYNC = 4;

  // ==========================================================================
  // Implemented (non-reserved) bits of each row
  localparam logic [7:0] REF_GROUP = 8'h07;
  localparam logic [7:0] VALID_SYSTEM_CLOCK_LOOP_WDOG_NVM = 8'h7B;
  localparam logic [7:0] VALID_REF = 8'h77;
  localparam logic [7:0] VALID_LOOP0_LOCK = 8'hFF;
  localparam logic [7:0] VALID_LOOP0_MODE = 8'hFF;
  localparam logic [7:0] VALID_ANALOG_LOOP0 = 8'h1F;
  localparam logic [7:0] VALID_ROW [NUM_ROWS] = '{
    VALID_SYSTEM_CLOCK_LOOP_WDOG_NVM, VALID_REF, VALID_REF,
    VALID_LOOP0_LOCK, VALID_LOOP0_MODE, VALID_ANALOG_LOOP0};

  // ==========================================================================
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ---- hw/mask_row.sv ----
// Purpose: One 8-bit interrupt mask register with its event gate
// Assumes: Events are one-cycle pulses on the same clock
// Notes: Reserved positions never store and never pass an event
`timescale 1ns/1ps
module mask_row #(
  parameter logic [7:0] VALID = 8'hFF
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Register write
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  // Events
  input wire logic [7:0] event_i,
  output logic [7:0] mask_o,
  output logic [7:0] record_o
);

  // ==========================================================================
  // Mask storage
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_o <= irq_mask_pkg::MASK_RESET; // [RULE3]
    end else if (wr_en_i) begin
      mask_o <= wr_data_i & VALID; // [RULE23]
    end
  end

  // ==========================================================================
  // Bit i of the mask gates bit i of the event row only
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      record_o <= 8'h00;
    end else begin
      record_o <= event_i & mask_o & VALID; // [RULE1] [RULE2] [RULE3] [RULE23]
    end
  end

endmodule

// ---- hw/sticky_flag.sv ----
// Purpose: Sticky flag set by hardware, cleared by a write of one
// Assumes: Set and clear are same-clock pulses
// Notes: A set in the clearing cycle wins so no event is lost
`timescale 1ns/1ps
module sticky_flag (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Control
  input wire logic set_i,
  input wire logic clear_i,
  output logic flag_o
);

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clear_i) begin
      flag_o <= 1'b0;
    end
  end

endmodule

// ---- hw/irq_mask_bank.sv ----
// Purpose: Interrupt mask bank for a dual-loop clock translator, AXI4-Lite slave
// Assumes: Event inputs are one-cycle pulses from logic on clock_i
// Notes: Recorded events appear one cycle after the event, gated by the mask
`timescale 1ns/1ps

// How it works
// [RULE1] Mask bit gates same-position monitor bit
// [RULE2] Mask one lets the event record
// [RULE3] Masks reset to zero, zero blocks events
// [RULE4] Row 0 bit 6: system loop unlocked
// [RULE5] Row 0 bit 5: system loop stable
// [RULE6] Row 0 bit 4: system loop locked
// [RULE7] Row 0 bit 3: watchdog expired
// [RULE8] Row 0 bit 1: memory load/save fault
// [RULE9] Row 0 bit 0: memory load/save done
// [RULE10] Two reference rows, bits 7,3 reserved
// [RULE11] Group low bit: reference faulted
// [RULE12] Group middle bit: fault cleared
// [RULE13] Group high bit: reference validated
// [RULE14] Lock row bits 0,1: phase lock/loss
// [RULE15] Lock row bits 2,3: frequency lock/loss
// [RULE16] Lock row bits 4,5: slew limit enter/leave
// [RULE17] Lock row bits 6,7: clamp enter/exit
// [RULE18] Mode row bits 0-3: reference A-D activated
// [RULE19] Mode row bit 4: history updated
// [RULE20] Mode row bits 5-7: holdover, free run, switching
// [RULE21] Analog row bits 0,1: calibration start/done
// [RULE22] Analog row bits 2-4: lock, unlock, sync
// [RULE23] Reserved bits read zero, ignore writes
module irq_mask_bank (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,

  // AXI4-Lite write address
  input wire logic awvalid_i,
  input wire logic [11:0] awaddr_i,
  input wire logic [2:0] awprot_i,
  output logic awready_o,
  // AXI4-Lite write data
  input wire logic wvalid_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  output logic wready_o,
  // AXI4-Lite write response
  output logic bvalid_o,
  output logic [1:0] bresp_o,
  input wire logic bready_i,
  // AXI4-Lite read address
  input wire logic arvalid_i,
  input wire logic [11:0] araddr_i,
  input wire logic [2:0] arprot_i,
  output logic arready_o,
  // AXI4-Lite read data
  output logic rvalid_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  input wire logic rready_i,

  // Raw event pulses, one row per mask register
  input wire logic [7:0] system_clock_loop_wdog_nvm_event_i,
  input wire logic [7:0] ref_ab_event_i,
  input wire logic [7:0] ref_cd_event_i,
  input wire logic [7:0] loop0_lock_event_i,
  input wire logic [7:0] loop0_mode_event_i,
  input wire logic [7:0] analog_loop0_event_i,

  // Events passed to the monitor, one cycle after the raw event
  output logic [7:0] system_clock_loop_wdog_nvm_record_o,
  output logic [7:0] ref_ab_record_o,
  output logic [7:0] ref_cd_record_o,
  output logic [7:0] loop0_lock_record_o,
  output logic [7:0] loop0_mode_record_o,
  output logic [7:0] analog_loop0_record_o,

  // Current mask values
  output logic [7:0] system_clock_loop_wdog_nvm_irq_mask_o,
  output logic [7:0] ref_ab_irq_mask_o,
  output logic [7:0] ref_cd_irq_mask_o,
  output logic [7:0] loop0_lock_irq_mask_o,
  output logic [7:0] loop0_mode_irq_mask_o,
  output logic [7:0] analog_loop0_irq_mask_o
);

  typedef enum logic [0:0] {
    WR_COLLECT,
    WR_RESPOND
  } wr_state_t;

  localparam int unsigned ROWS = irq_mask_pkg::NUM_ROWS;

  wr_state_t wr_state_q;
  logic aw_held_q;
  logic w_held_q;
  logic [9:0] aw_idx_q;
  logic [7:0] w_byte_q;
  logic w_lane_q;
  logic [7:0] event_row [ROWS];
  logic [7:0] mask_row_q [ROWS];
  logic [7:0] record_row_q [ROWS];
  logic [ROWS-1:0] row_wr_en;
  logic [ROWS-1:0] summary_q;
  logic [ROWS-1:0] summary_clear;
  logic [9:0] wr_off;
  logic [9:0] rd_idx;
  logic [9:0] rd_off;
  logic wr_commit;
  logic wr_row_hit;
  logic wr_summary_hit;
  logic rd_hit;
  logic [7:0] rd_byte;

  // ==========================================================================
  // Event rows: position of each bit is fixed by the field constants
  assign event_row[0] = system_clock_loop_wdog_nvm_event_i; // [RULE4] [RULE5] [RULE6] [RULE7] [RULE8] [RULE9]
  assign event_row[1] = ref_ab_event_i; // [RULE10] [RULE11] [RULE12] [RULE13]
  assign event_row[2] = ref_cd_event_i; // [RULE10] [RULE11] [RULE12] [RULE13]
  assign event_row[3] = loop0_lock_event_i; // [RULE14] [RULE15] [RULE16] [RULE17]
  assign event_row[4] = loop0_mode_event_i; // [RULE18] [RULE19] [RULE20]
  assign event_row[5] = analog_loop0_event_i; // [RULE21] [RULE22]

  // ==========================================================================
  // Write channel: address and data taken independently, in either order
  assign wr_commit = (wr_state_q == WR_COLLECT) && aw_held_q && w_held_q;
  assign wr_off = aw_idx_q - irq_mask_pkg::IDX_FIRST_ROW;
  assign wr_row_hit = (aw_idx_q >= irq_mask_pkg::IDX_FIRST_ROW) && (wr_off < 10'(ROWS));
  assign wr_summary_hit = (aw_idx_q == irq_mask_pkg::IDX_RECORD_SUMMARY);

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held_q <= 1'b0;
      aw_idx_q <= 10'h000;
      awready_o <= 1'b1;
    end else if (awvalid_i && awready_o) begin
      aw_held_q <= 1'b1;
      aw_idx_q <= awaddr_i[11:2];
      awready_o <= 1'b0;
    end else if (bvalid_o && bready_i) begin
      aw_held_q <= 1'b0;
      awready_o <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      w_held_q <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
      wready_o <= 1'b1;
    end else if (wvalid_i && wready_o) begin
      w_held_q <= 1'b1;
      w_byte_q <= wdata_i[7:0];
      w_lane_q <= wstrb_i[0];
      wready_o <= 1'b0;
    end else if (bvalid_o && bready_i) begin
      w_held_q <= 1'b0;
      wready_o <= 1'b1;
    end
  end

  // Response follows the commit; an unmapped address answers DECERR
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_state_q <= WR_COLLECT;
      bvalid_o <= 1'b0;
      bresp_o <= irq_mask_pkg::RESP_OKAY;
    end else begin
      case (wr_state_q)
        WR_COLLECT: begin
          if (wr_commit) begin
            bvalid_o <= 1'b1;
            bresp_o <= (wr_row_hit || wr_summary_hit) ? irq_mask_pkg::RESP_OKAY
                                                       : irq_mask_pkg::RESP_DECERR;
            wr_state_q <= WR_RESPOND;
          end
        end
        WR_RESPOND: begin
          if (bready_i) begin
            bvalid_o <= 1'b0;
            wr_state_q <= WR_COLLECT;
          end
        end
        default: begin
          bvalid_o <= 1'b0;
          wr_state_q <= WR_COLLECT;
        end
      endcase
    end
  end

  // ==========================================================================
  // Mask rows and their gates; only byte lane 0 carries register data
  genvar r;
  generate
    for (r = 0; r < ROWS; r++) begin : g_row
      assign row_wr_en[r] = wr_commit && wr_row_hit && w_lane_q && (wr_off == 10'(r));
      assign summary_clear[r] = wr_commit && wr_summary_hit && w_lane_q && w_byte_q[r];

      mask_row #(
        .VALID(irq_mask_pkg::VALID_ROW[r])
      ) u_mask_row (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(row_wr_en[r]),
        .wr_data_i(w_byte_q),
        .event_i(event_row[r]),
        .mask_o(mask_row_q[r]),
        .record_o(record_row_q[r])
      ); // [RULE1] [RULE2] [RULE3] [RULE23]

      // Row summary: any recorded event since the last clear
      sticky_flag u_summary (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .set_i(|record_row_q[r]),
        .clear_i(summary_clear[r]),
        .flag_o(summary_q[r])
      );
    end
  endgenerate

  assign system_clock_loop_wdog_nvm_irq_mask_o = mask_row_q[0];
  assign ref_ab_irq_mask_o = mask_row_q[1];
  assign ref_cd_irq_mask_o = mask_row_q[2];
  assign loop0_lock_irq_mask_o = mask_row_q[3];
  assign loop0_mode_irq_mask_o = mask_row_q[4];
  assign analog_loop0_irq_mask_o = mask_row_q[5];

  assign system_clock_loop_wdog_nvm_record_o = record_row_q[0];
  assign ref_ab_record_o = record_row_q[1];
  assign ref_cd_record_o = record_row_q[2];
  assign loop0_lock_record_o = record_row_q[3];
  assign loop0_mode_record_o = record_row_q[4];
  assign analog_loop0_record_o = record_row_q[5];

  // ==========================================================================
  // Read channel: data registered one cycle after the address is taken
  assign rd_idx = araddr_i[11:2];
  assign rd_off = rd_idx - irq_mask_pkg::IDX_FIRST_ROW;

  always_comb begin
    rd_hit = 1'b0;
    rd_byte = 8'h00;
    if ((rd_idx >= irq_mask_pkg::IDX_FIRST_ROW) && (rd_off < 10'(ROWS))) begin
      rd_hit = 1'b1;
      rd_byte = mask_row_q[rd_off[2:0]]; // [RULE23]
    end else if (rd_idx == irq_mask_pkg::IDX_RECORD_SUMMARY) begin
      rd_hit = 1'b1;
      rd_byte = {2'h0, summary_q};
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arready_o <= 1'b1;
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      rresp_o <= irq_mask_pkg::RESP_OKAY;
    end else if (arvalid_i && arready_o) begin
      arready_o <= 1'b0;
      rvalid_o <= 1'b1;
      rdata_o <= {24'h00_0000, rd_byte};
      rresp_o <= rd_hit ? irq_mask_pkg::RESP_OKAY : irq_mask_pkg::RESP_DECERR;
    end else if (rvalid_o && rready_i) begin
      rvalid_o <= 1'b0;
      arready_o <= 1'b1;
    end
  end

endmodule

// ---- dv/irq_mask_bank_monitor.sv ----
// Purpose: Port checker for the interrupt mask bank
// Assumes: One clock, asynchronous active-low reset
// Notes: Watches a subset of the top ports; bound by name
`timescale 1ns/1ps
module irq_mask_bank_monitor (
  // Clock, reset and bus handshakes
  input wire logic clock_i, reset_n_i, awvalid_i, awready_o, wvalid_i, wready_o,
  input wire logic bvalid_o, bready_i, arvalid_i, arready_o, rvalid_o,
  input wire logic [1:0] bresp_o,
  // Events, records and masks
  input wire logic [7:0] system_clock_loop_wdog_nvm_event_i, system_clock_loop_wdog_nvm_record_o,
  input wire logic [7:0] system_clock_loop_wdog_nvm_irq_mask_o, ref_ab_irq_mask_o,
  input wire logic [7:0] analog_loop0_event_i, analog_loop0_record_o, analog_loop0_irq_mask_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // ==========================================================================
  // Event gating
  a_row0_record_gate: assert property (
    system_clock_loop_wdog_nvm_record_o == ($past(system_clock_loop_wdog_nvm_event_i)
      & $past(system_clock_loop_wdog_nvm_irq_mask_o) & 8'h7B)) else $error("row 0 record wrong");
  a_analog_record_gate: assert property (
    analog_loop0_record_o == ($past(analog_loop0_event_i)
      & $past(analog_loop0_irq_mask_o) & 8'h1F)) else $error("analog record wrong");
  a_reserved_bits_zero: assert property (
    (system_clock_loop_wdog_nvm_irq_mask_o & 8'h84) == 8'h00 && (ref_ab_irq_mask_o & 8'h88) == 8'h00
      && (analog_loop0_irq_mask_o & 8'hE0) == 8'h00) else $error("reserved mask bit set");
  // Checked while reset is low, so the default disable is overridden
  a_reset_masks_zero: assert property (@(posedge clock_i) disable iff (1'b0)
    !reset_n_i |-> (system_clock_loop_wdog_nvm_irq_mask_o | analog_loop0_irq_mask_o) == 8'h00)
    else $error("mask not zero in reset");
  a_mask_needs_write: assert property (
    !$stable(system_clock_loop_wdog_nvm_irq_mask_o) || !$stable(analog_loop0_irq_mask_o)
      |-> $rose(bvalid_o)) else $error("mask changed without write");
  // ==========================================================================
  // Bus timing
  a_write_accept: assert property (awvalid_i && awready_o && wvalid_i && wready_o
    |=> !awready_o && !bvalid_o ##1 bvalid_o) else $error("write answer late");
  a_bresp_holds: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write response dropped");
  a_read_answer: assert property (arvalid_i && arready_o |=> rvalid_o && !arready_o)
    else $error("read answer late");
endmodule
bind irq_mask_bank irq_mask_bank_monitor mon (.*);

// ---- dv/irq_mask_bank_test.sv ----
// Purpose: Self-checking bench for the interrupt mask bank
// Assumes: Bench is the AXI4-Lite master and the event source
// Notes: Drivers queue expectations, a falling-edge watcher compares
`timescale 1ns/1ps
module irq_mask_bank_test;
  logic clock_i = 1'b0;
  // Starts high so the first assertion of reset is a real falling edge
  logic reset_n_i = 1'b1;
  logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
  logic [11:0] awaddr_i = 12'h000, araddr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic [3:0] wstrb_i = 4'h1;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic [1:0] bresp_o, rresp_o;
  logic [31:0] rdata_o;
  logic [7:0] ev [6] = '{default: 8'h00};
  logic [7:0] rec [6];
  logic [7:0] model [6];
  logic [7:0] mask_seen [6];
  logic [47:0] ev_prev_q = 48'h0;
  logic [33:0] rd_q [$];
  logic [1:0] b_q [$];
  logic [47:0] rec_q [$];
  logic [31:0] seed = 32'h592FB971;
  logic [5:0] sum_exp;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;

  irq_mask_bank dut (.*, .awprot_i(3'h0), .arprot_i(3'h0),
    .system_clock_loop_wdog_nvm_event_i(ev[0]), .ref_ab_event_i(ev[1]), .ref_cd_event_i(ev[2]),
    .loop0_lock_event_i(ev[3]), .loop0_mode_event_i(ev[4]), .analog_loop0_event_i(ev[5]),
    .system_clock_loop_wdog_nvm_record_o(rec[0]), .ref_ab_record_o(rec[1]), .ref_cd_record_o(rec[2]),
    .loop0_lock_record_o(rec[3]), .loop0_mode_record_o(rec[4]), .analog_loop0_record_o(rec[5]),
    .system_clock_loop_wdog_nvm_irq_mask_o(mask_seen[0]), .ref_ab_irq_mask_o(mask_seen[1]),
    .ref_cd_irq_mask_o(mask_seen[2]), .loop0_lock_irq_mask_o(mask_seen[3]),
    .loop0_mode_irq_mask_o(mask_seen[4]), .analog_loop0_irq_mask_o(mask_seen[5]));

  initial begin
    forever #5 clock_i = ~clock_i;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [11:0] adr(input int r);
    return {irq_mask_pkg::IDX_FIRST_ROW + 10'(r), 2'b00};
  endfunction

  task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Checked %0d samples, %0d errors", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] resp);
    logic aw_done = 1'b0;
    logic w_done = 1'b0;
    logic [31:0] r = rnd();
    @(posedge clock_i);
    awvalid_i <= 1'b1;
    awaddr_i <= a;
    wvalid_i <= 1'b1;
    wdata_i <= {r[31:8], d};
    bready_i <= 1'b1;
    b_q.push_back(resp);
    while (!(aw_done && w_done)) begin
      @(posedge clock_i);
      aw_done |= awready_o;
      w_done |= wready_o;
      awvalid_i <= !aw_done;
      wvalid_i <= !w_done;
    end
    do @(posedge clock_i); while (!bvalid_o);
    bready_i <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] exp);
    @(posedge clock_i);
    arvalid_i <= 1'b1;
    araddr_i <= a;
    rready_i <= 1'b1;
    rd_q.push_back(exp);
    do @(posedge clock_i); while (!arready_o);
    arvalid_i <= 1'b0;
    do @(posedge clock_i); while (!rvalid_o);
    rready_i <= 1'b0;
  endtask

  // Model moves first: the mask outputs are checked at the write response
  task automatic setm(input int r, input logic [7:0] d);
    model[r] = d & irq_mask_pkg::VALID_ROW[r];
    wr(adr(r), d, irq_mask_pkg::RESP_OKAY);
  endtask

  // One-cycle event pulse; records are due one cycle later
  task automatic pulse(input logic [47:0] e);
    logic [47:0] x;
    @(posedge clock_i);
    for (int r = 0; r < 6; r++) begin
      ev[r] <= e[r*8 +: 8];
      x[r*8 +: 8] = e[r*8 +: 8] & model[r] & irq_mask_pkg::VALID_ROW[r];
      if (x[r*8 +: 8] != 8'h00) sum_exp[r] = 1'b1;
    end
    if (e != 48'h0) rec_q.push_back(x);
    @(posedge clock_i);
    for (int r = 0; r < 6; r++) ev[r] <= 8'h00;
  endtask

  task automatic do_reset();
    reset_n_i <= 1'b0;
    for (int r = 0; r < 6; r++) model[r] = 8'h00;
    sum_exp = 6'h00;
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
  endtask

  // ==========================================================================
  // Watchers
  always @(posedge clock_i) ev_prev_q <= {ev[5], ev[4], ev[3], ev[2], ev[1], ev[0]};
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  always @(negedge clock_i) begin
    if (rvalid_o && rready_i && rd_q.size() > 0) chk("rdata", {rresp_o, rdata_o}, rd_q.pop_front());
    if (bvalid_o && bready_i && b_q.size() > 0) begin
      chk("bresp", bresp_o, b_q.pop_front());
      for (int r = 0; r < 6; r++) chk("mask", mask_seen[r], model[r]);
    end
    if (ev_prev_q != 48'h0 && rec_q.size() > 0) chk("record", {rec[5], rec[4], rec[3], rec[2], rec[1], rec[0]}, rec_q.pop_front());
  end

  // ==========================================================================
  // Sequence
  initial begin
    do_reset();
    for (int r = 0; r < 6; r++) rd(adr(r), {irq_mask_pkg::RESP_OKAY, 32'h0});
    pulse({6{8'hFF}});
    $display("Test reset defaults done");
    for (int r = 0; r < 6; r++) begin
      for (int b = 0; b < 8; b++) begin
        setm(r, 8'h01 << b);
        rd(adr(r), {irq_mask_pkg::RESP_OKAY, 24'h0, model[r]});
        pulse({6{8'hFF}});
      end
    end
    $display("Test walking mask done");
    rd({irq_mask_pkg::IDX_RECORD_SUMMARY, 2'b00}, {irq_mask_pkg::RESP_OKAY, 26'h0, sum_exp});
    wr({irq_mask_pkg::IDX_RECORD_SUMMARY, 2'b00}, 8'h3F, irq_mask_pkg::RESP_OKAY);
    sum_exp = 6'h00;
    rd({irq_mask_pkg::IDX_RECORD_SUMMARY, 2'b00}, {irq_mask_pkg::RESP_OKAY, 32'h0});
    $display("Test record summary done");
    repeat (20) begin
      for (int r = 0; r < 6; r++) setm(r, 8'(rnd()));
      rd(adr(5), {irq_mask_pkg::RESP_OKAY, 24'h0, model[5]});
      pulse(48'({rnd(), rnd()}));
      pulse(48'({rnd(), rnd()}));
    end
    $display("Test random masks done");
    wr(12'h400, 8'hFF, irq_mask_pkg::RESP_DECERR);
    rd(12'h400, {irq_mask_pkg::RESP_DECERR, 32'h0});
    $display("Test unmapped address done");
    // Lane 0 strobe low: answered OKAY, mask left alone
    wstrb_i <= 4'h0;
    wr(adr(3), 8'hA5, irq_mask_pkg::RESP_OKAY);
    wstrb_i <= 4'h1;
    rd(adr(3), {irq_mask_pkg::RESP_OKAY, 24'h0, model[3]});
    $display("Test strobe low done");
    setm(0, 8'hFF);
    do_reset();
    rd(adr(0), {irq_mask_pkg::RESP_OKAY, 32'h0});
    pulse({6{8'hFF}});
    $display("Test mid-run reset done");
    repeat (4) @(posedge clock_i);
    test_done();
  end
endmodule
